// ### include/hss_pkg.sv
`default_nettype none
// ****************************************************
// Sequencer constants
// ****************************************************
package hss_pkg;
    // Clock period and derived cycles per microsecond
    localparam int CLK_PERIOD_NS = 10;
    localparam int CYC_PER_US = 1000 / CLK_PERIOD_NS;
    // Counter width, wide enough for the longest wait
    localparam int CNT_W = 32;
    // Times in microseconds, as figures
    localparam int T_SETTLE_US = 220000;   // Startup settle, 220 ms
    localparam int T_PROBE_US = 220000;    // Probe period, 220 ms
    localparam int T_ON_LOW_US = 1500;     // Turn-on inputs low, 1.5 ms
    localparam int T_BREAKER_US = 1200;    // Breaker glitch rejection, 1.2 ms
    localparam int T_GOOD_US = 1260;       // Power-good delay, 1.26 ms
    localparam int T_STEP_OFF_US = 350;    // Step cycle drive off, 350 us
    localparam int T_STEP_RAMP_US = 1000;  // Step cycle ramp start, 1 ms
    localparam int T_RETRY_US = 3500000;   // Autoretry wait, 3.5 s
    localparam int PROBE_RETRY_MULT = 16;  // Probe periods after failed probe
    // Derived cycle counts
    localparam logic [CNT_W-1:0] SETTLE_CYC = CNT_W'(T_SETTLE_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] PROBE_CYC = CNT_W'(T_PROBE_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] ON_LOW_CYC = CNT_W'(T_ON_LOW_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] BREAKER_CYC = CNT_W'(T_BREAKER_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] GOOD_CYC = CNT_W'(T_GOOD_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] STEP_OFF_CYC = CNT_W'(T_STEP_OFF_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] STEP_RAMP_CYC = CNT_W'(T_STEP_RAMP_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] RETRY_CYC = CNT_W'(longint'(T_RETRY_US) * CYC_PER_US);
    localparam logic [CNT_W-1:0] ZERO_CNT = 32'h0000_0000;
    localparam logic [CNT_W-1:0] ONE_CNT = 32'h0000_0001;
    // Sequencer states, Gray coded along the usual path
    typedef enum logic [2:0] {
        HSS_IDLE = 3'h0,
        HSS_SETTLE = 3'h1,
        HSS_PROBE = 3'h3,
        HSS_RAMP = 3'h2,
        HSS_FULL = 3'h6,
        HSS_STEP_OFF = 3'h7,
        HSS_FAULT = 3'h5,
        HSS_RETRY = 3'h4
    } hss_state_t;
endpackage
`default_nettype wire

// ### tb/hss_load_model.sv
`default_nettype none
// ********************
// Switch and load as comparator results
// ********************
module hss_load_model (
    input wire logic i_clk,
    input wire logic i_probe_on,  // Probe current flowing
    input wire logic i_ramp,      // Gate charging slowly
    input wire logic i_full,      // Gate pulled to full
    input wire logic i_off,       // Gate pulled down
    input wire logic i_shorted,   // Load is a short
    input wire logic i_heavy,     // Output stays above 74 percent
    output logic o_load_above_200mv,
    output logic o_out_below_74,
    output logic o_drive_at_90,
    output logic o_drive_full
);
    logic [3:0] gate_r = 4'h0;  // Gate level in sixteenths
    // Gate follows the drive, one step a cycle while ramping
    always @(negedge i_clk) begin
        if (i_off) begin
            gate_r <= 4'h0;
        end else if (i_full) begin
            gate_r <= 4'hf;
        end else if (i_ramp && gate_r < 4'he) begin
            gate_r <= gate_r + 4'h1;
        end
    end
    assign o_load_above_200mv = i_probe_on && !i_shorted;
    assign o_out_below_74 = !i_heavy && gate_r >= 4'h6;
    assign o_drive_at_90 = gate_r >= 4'hc;
    assign o_drive_full = gate_r == 4'hf;
endmodule
`default_nettype wire

// ### tb/hss_sequencer_properties.sv
`default_nettype none
// ********************
// Sequencer port checks
// ********************
module hss_seq_props #(
    parameter int P_BREAKER_CYC = 120000,
    parameter int P_GOOD_CYC = 126000
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_on_above,
    input wire logic i_off_above,
    input wire logic i_overvoltage_in,
    input wire logic i_load_above_200mv,
    input wire logic i_out_below_74,
    input wire logic i_out_above_breaker,
    input wire logic i_out_above_short,
    input wire logic i_input_step_sense,
    input wire logic i_drive_at_90,
    input wire logic i_drive_full,
    input wire logic i_good_polarity_select,
    input wire logic o_probe_current_pin,
    input wire logic o_drive_ramp,
    input wire logic o_drive_full,
    input wire logic o_drive_off,
    input wire logic o_power_good_out,
    input wire logic o_fault
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    wire sup_ok = i_on_above && i_off_above && !i_overvoltage_in;  // Supply inside limits
    wire good_act = o_power_good_out ^ i_good_polarity_select;     // Good, active sense
    // Breaker window at full drive, no step
    wire brk = o_drive_full && i_drive_full && i_out_above_breaker && !i_out_above_short
        && !i_input_step_sense && sup_ok;
    logic [31:0] full_cnt_r;  // Cycles with full drive
    logic [31:0] brk_cnt_r;   // Cycles in breaker window
    // Run lengths for the timed checks
    always_ff @(posedge i_clk) begin
        full_cnt_r <= (i_sys_rst || !o_drive_full) ? 32'h0 : full_cnt_r + 32'h1;
        brk_cnt_r <= (i_sys_rst || !brk) ? 32'h0 : brk_cnt_r + 32'h1;
    end
    sequence s_ramp_on;
        o_drive_ramp && sup_ok;
    endsequence
    property p_probe_first;
        o_probe_current_pin |-> !o_drive_ramp && !o_drive_full;
    endproperty
    a_probe_first: assert property (p_probe_first) else $error("drive during probe");
    property p_probe_pass;
        o_probe_current_pin && i_load_above_200mv && sup_ok |-> ##[1:2] o_drive_ramp;
    endproperty
    a_probe_pass: assert property (p_probe_pass) else $error("no ramp after probe");
    property p_ramp_keep;
        s_ramp_on ##0 (!i_out_below_74 && !i_drive_at_90) |=> o_drive_ramp;
    endproperty
    a_ramp_keep: assert property (p_ramp_keep) else $error("ramp dropped");
    property p_full_fast;
        s_ramp_on ##0 i_out_below_74 |-> ##[1:2] o_drive_full;
    endproperty
    a_full_fast: assert property (p_full_fast) else $error("no full drive");
    property p_ramp_fault;
        s_ramp_on ##0 (i_drive_at_90 && !i_out_below_74 && !i_input_step_sense)
            |-> ##[1:2] (o_fault && !good_act);
    endproperty
    a_ramp_fault: assert property (p_ramp_fault) else $error("no ramp fault");
    property p_short_fault;
        o_drive_full && i_out_above_short && !i_input_step_sense && sup_ok
            |-> ##[1:2] (o_fault && o_drive_off && !good_act);
    endproperty
    a_short_fault: assert property (p_short_fault) else $error("short not tripped");
    property p_step_keep;
        o_drive_full && i_input_step_sense && i_out_above_short && sup_ok && good_act
            |-> ##[1:2] (o_drive_off && good_act && !o_fault);
    endproperty
    a_step_keep: assert property (p_step_keep) else $error("step cycle wrong");
    property p_fault_off;
        o_fault |-> o_drive_off && !o_drive_ramp && !o_drive_full && !good_act;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("drive in fault");
    property p_ov_off;
        i_overvoltage_in [*2] |-> o_drive_off && !o_drive_ramp && !o_drive_full;
    endproperty
    a_ov_off: assert property (p_ov_off) else $error("drive on overvoltage");
    property p_brk_late;
        brk_cnt_r <= P_BREAKER_CYC + 2;
    endproperty
    a_brk_late: assert property (p_brk_late) else $error("breaker trip late");
    property p_brk_early;
        $fell(o_drive_full) && $past(brk) |-> $past(brk_cnt_r) >= P_BREAKER_CYC - 2;
    endproperty
    a_brk_early: assert property (p_brk_early) else $error("breaker trip early");
    property p_good_delay;
        $rose(good_act) |-> full_cnt_r >= P_GOOD_CYC - 1 && full_cnt_r <= P_GOOD_CYC + 2;
    endproperty
    a_good_delay: assert property (p_good_delay) else $error("good delay wrong");
endmodule
bind hss_sequencer hss_seq_props #(
    .P_BREAKER_CYC(P_BREAKER_CYC),
    .P_GOOD_CYC(P_GOOD_CYC)
) i_hss_seq_props (
    .i_clk, .i_sys_rst, .i_on_above, .i_off_above, .i_overvoltage_in, .i_load_above_200mv,
    .i_out_below_74, .i_out_above_breaker, .i_out_above_short, .i_input_step_sense,
    .i_drive_at_90, .i_drive_full, .i_good_polarity_select, .o_probe_current_pin,
    .o_drive_ramp, .o_drive_full, .o_drive_off, .o_power_good_out, .o_fault
);
`default_nettype wire

// ### tb/hss_sequencer_tb.sv
`default_nettype none
module hss_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ********************
    // Stimulus and shortened timing
    // ********************
    localparam int SETTLE = 32'h14;
    localparam int PROBE = 32'h14;
    localparam int ONLOW = 32'ha;
    localparam int BRK = 32'ha;
    localparam int GOOD = 32'hc;
    localparam int STOFF = 32'h4;
    localparam int STRAMP = 32'ha;
    localparam int RETRY = 32'h1e;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_on_above = 1'b0;
    logic i_off_above = 1'b0;
    logic i_overvoltage_in = 1'b0;
    logic i_out_above_breaker = 1'b0;
    logic i_out_above_short = 1'b0;
    logic i_input_step_sense = 1'b0;
    logic i_good_polarity_select = 1'b1;
    logic i_latched_variant = 1'b0;
    logic shorted = 1'b0;  // Load shorted
    logic heavy = 1'b0;    // Output never under 74 percent
    logic i_load_above_200mv, i_out_below_74, i_drive_at_90, i_drive_full;
    logic o_probe_current_pin, o_drive_ramp, o_drive_full, o_drive_off, o_power_good_out, o_fault;
    int err_total = 0;
    int checked = 0;
    int n;
    hss_sequencer #(.P_SETTLE_CYC(SETTLE), .P_PROBE_CYC(PROBE), .P_ON_LOW_CYC(ONLOW),
        .P_BREAKER_CYC(BRK), .P_GOOD_CYC(GOOD), .P_STEP_OFF_CYC(STOFF),
        .P_STEP_RAMP_CYC(STRAMP), .P_RETRY_CYC(RETRY)) i_hss_sequencer (
        .i_clk, .i_sys_rst, .i_on_above, .i_off_above, .i_overvoltage_in, .i_load_above_200mv,
        .i_out_below_74, .i_out_above_breaker, .i_out_above_short, .i_input_step_sense,
        .i_drive_at_90, .i_drive_full, .i_good_polarity_select, .i_latched_variant,
        .o_probe_current_pin, .o_drive_ramp, .o_drive_full, .o_drive_off, .o_power_good_out,
        .o_fault);
    hss_load_model i_hss_load_model (.i_clk, .i_probe_on(o_probe_current_pin),
        .i_ramp(o_drive_ramp), .i_full(o_drive_full), .i_off(o_drive_off), .i_shorted(shorted),
        .i_heavy(heavy), .o_load_above_200mv(i_load_above_200mv),
        .o_out_below_74(i_out_below_74), .o_drive_at_90(i_drive_at_90),
        .o_drive_full(i_drive_full));
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    // Watched output by index; 4 is good in its active sense
    function automatic logic sig(input logic [2:0] k);
        case (k)
            3'h0: sig = o_probe_current_pin;
            3'h1: sig = o_drive_ramp;
            3'h2: sig = o_drive_full;
            3'h3: sig = o_drive_off;
            3'h4: sig = o_power_good_out ^ i_good_polarity_select;
            default: sig = o_fault;
        endcase
    endfunction
    // Bounded wait for a level, cycles waited in n
    task automatic wt(input logic [2:0] k, input logic lvl, input int lim);
        n = 0;
        while (sig(k) !== lvl && n < lim) begin
            @(negedge i_clk);
            n++;
        end
    endtask
    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic test_done;
        $display("Mismatches %0d of %0d checks", err_total, checked);
        if (err_total == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic t_up;
        i_on_above = 1'b1;
        i_off_above = 1'b1;
        wt(3'h0, 1'b1, 32'hc8);
        chk(n >= SETTLE && n < 32'hc8, "probe start");
        wt(3'h1, 1'b1, 32'h4);
        chk(n < 32'h4 && o_probe_current_pin === 1'b0, "ramp after probe");
        wt(3'h2, 1'b1, 32'h14);
        chk(n < 32'h14, "full drive");
        wt(3'h4, 1'b1, 32'h20);
        chk(n >= GOOD - 1 && n <= GOOD + 2 && o_power_good_out === 1'b0, "good delay");
    endtask
    task automatic t_brk;
        i_out_above_breaker = 1'b1;
        repeat (32'h5) @(negedge i_clk);
        i_out_above_breaker = 1'b0;
        @(negedge i_clk);
        chk(o_drive_full === 1'b1 && sig(3'h4) === 1'b1, "glitch rejected");
        i_out_above_breaker = 1'b1;
        wt(3'h5, 1'b1, 32'h14);
        chk(n >= BRK - 2 && n <= BRK + 2 && sig(3'h4) === 1'b0, "breaker trip");
        i_out_above_breaker = 1'b0;
        wt(3'h0, 1'b1, 32'h40);
        chk(n >= RETRY - 2 && n <= RETRY + 2, "retry wait");
        wt(3'h4, 1'b1, 32'h40);
        chk(n < 32'h40, "power good again");
    endtask
    task automatic t_step;
        i_input_step_sense = 1'b1;
        i_out_above_short = 1'b1;
        wt(3'h3, 1'b1, 32'h4);
        i_out_above_short = 1'b0;
        chk(n < 32'h4 && sig(3'h4) === 1'b1 && o_fault === 1'b0, "step cycle");
        wt(3'h3, 1'b0, 32'h10);
        chk(n >= STOFF - 2 && n <= STOFF + 1, "drive held off");
        wt(3'h1, 1'b1, 32'h10);
        chk(n + STOFF >= STRAMP - 3 && n + STOFF <= STRAMP + 2, "step ramp start");
        wt(3'h2, 1'b1, 32'h14);
        chk(n < 32'h14 && sig(3'h4) === 1'b1, "full in step");
        i_input_step_sense = 1'b0;
    endtask
    task automatic t_faults;
        i_out_above_short = 1'b1;
        repeat (32'h2) @(negedge i_clk);
        chk(o_fault === 1'b1 && o_drive_off === 1'b1 && sig(3'h4) === 1'b0, "short");
        i_out_above_short = 1'b0;
        heavy = 1'b1;
        wt(3'h1, 1'b1, 32'h40);
        wt(3'h5, 1'b1, 32'h20);
        chk(n >= 32'hb && n < 32'h20 && o_drive_full === 1'b0, "fault at 90 percent");
        heavy = 1'b0;
        shorted = 1'b1;
        wt(3'h0, 1'b1, 32'h40);
        wt(3'h5, 1'b1, 32'h20);
        chk(n >= PROBE - 2 && n <= PROBE + 2 && o_drive_ramp === 1'b0, "shorted load");
        wt(3'h0, 1'b1, 32'h200);
        chk(n >= 32'h10 * PROBE - 2 && n <= 32'h10 * PROBE + 2, "reprobe wait");
        shorted = 1'b0;
        wt(3'h4, 1'b1, 32'h40);
    endtask
    task automatic t_latched;
        i_sys_rst = 1'b1;
        i_latched_variant = 1'b1;
        i_good_polarity_select = 1'b0;
        shorted = 1'b1;
        repeat (32'ha) @(negedge i_clk);
        i_sys_rst = 1'b0;
        wt(3'h5, 1'b1, 32'h60);
        wt(3'h5, 1'b0, 32'h40);
        chk(n == 32'h40 && o_power_good_out === 1'b0, "fault latched");
        shorted = 1'b0;
        i_on_above = 1'b0;
        wt(3'h5, 1'b0, 32'h20);
        chk(n == 32'h20, "one input low holds");
        i_off_above = 1'b0;
        wt(3'h5, 1'b0, 32'h20);
        chk(n >= ONLOW - 2 && n <= ONLOW + 2, "latch cleared");
        i_on_above = 1'b1;
        i_off_above = 1'b1;
        wt(3'h4, 1'b1, 32'h80);
        chk(o_power_good_out === 1'b1, "active high good");
        i_overvoltage_in = 1'b1;
        repeat (32'h3) @(negedge i_clk);
        chk(o_drive_off === 1'b1 && o_drive_full === 1'b0, "overvoltage off");
    endtask
    // Main sequence
    initial begin
        repeat (32'ha) @(negedge i_clk);
        i_sys_rst = 1'b0;
        chk(o_drive_off === 1'b1 && o_fault === 1'b0, "reset state");
        t_up();
        t_brk();
        t_step();
        t_faults();
        t_latched();
        test_done();
    end
    // Watchdog
    initial begin
        repeat (32'h2000) @(posedge i_clk);
        err_total++;
        test_done();
    end
endmodule
`default_nettype wire

// ### verilog/hss_sequencer.sv
`default_nettype none
module hss_sequencer #(
    parameter logic [31:0] P_SETTLE_CYC = hss_pkg::SETTLE_CYC,
    parameter logic [31:0] P_PROBE_CYC = hss_pkg::PROBE_CYC,
    parameter logic [31:0] P_ON_LOW_CYC = hss_pkg::ON_LOW_CYC,
    parameter logic [31:0] P_BREAKER_CYC = hss_pkg::BREAKER_CYC,
    parameter logic [31:0] P_GOOD_CYC = hss_pkg::GOOD_CYC,
    parameter logic [31:0] P_STEP_OFF_CYC = hss_pkg::STEP_OFF_CYC,
    parameter logic [31:0] P_STEP_RAMP_CYC = hss_pkg::STEP_RAMP_CYC,
    parameter logic [31:0] P_RETRY_CYC = hss_pkg::RETRY_CYC
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_on_above,             // Turn-on input above its threshold
    input wire logic i_off_above,            // Turn-off input above its threshold
    input wire logic i_overvoltage_in,       // Supply above overvoltage threshold
    input wire logic i_load_above_200mv,     // Probe sees more than 200mV on load
    input wire logic i_out_below_74,         // Output below 74 percent of breaker
    input wire logic i_out_above_breaker,    // Output above breaker_threshold
    input wire logic i_out_above_short,      // Output above short_threshold
    input wire logic i_input_step_sense,     // Step comparator above step_threshold
    input wire logic i_drive_at_90,          // Drive reached 90 percent
    input wire logic i_drive_full,           // Drive reached full enhancement
    input wire logic i_good_polarity_select, // High when left open: active low
    input wire logic i_latched_variant,      // High: latched, low: autoretry
    output logic o_probe_current_pin,        // Probe current enable
    output logic o_drive_ramp,               // Controlled ramp of switch drive
    output logic o_drive_full,               // Rapid pull to full enhancement
    output logic o_drive_off,                // Strong pulldown of switch drive
    output logic o_power_good_out,           // Power-good, polarity applied; driven low during reset in either polarity
    output logic o_fault                     // Fault handling active
);
    // ****************************************************
    // Declarations
    // ****************************************************
    // Local names for the package states, nothing imported
    localparam hss_pkg::hss_state_t HSS_IDLE = hss_pkg::HSS_IDLE;
    localparam hss_pkg::hss_state_t HSS_SETTLE = hss_pkg::HSS_SETTLE;
    localparam hss_pkg::hss_state_t HSS_PROBE = hss_pkg::HSS_PROBE;
    localparam hss_pkg::hss_state_t HSS_RAMP = hss_pkg::HSS_RAMP;
    localparam hss_pkg::hss_state_t HSS_FULL = hss_pkg::HSS_FULL;
    localparam hss_pkg::hss_state_t HSS_STEP_OFF = hss_pkg::HSS_STEP_OFF;
    localparam hss_pkg::hss_state_t HSS_FAULT = hss_pkg::HSS_FAULT;
    localparam hss_pkg::hss_state_t HSS_RETRY = hss_pkg::HSS_RETRY;
    hss_pkg::hss_state_t state_r, state_nxt;     // Sequencer state
    logic [31:0] tmr_r, tmr_nxt;                 // Shared state timer
    logic [31:0] brk_r, brk_nxt;                 // Breaker rejection timer
    logic [31:0] onlow_r, onlow_nxt;             // Both-inputs-low timer
    logic [31:0] retry_lim_r, retry_lim_nxt;     // Wait chosen at fault entry
    logic on_latch_r, on_latch_nxt;              // Turn-on latch
    logic step_cyc_r, step_cyc_nxt;              // Ramp belongs to a step cycle
    logic good_r, good_nxt;                      // Internal power-good
    logic probe_r, ramp_r, full_r, off_r, fault_r, pg_pin_r;
    // ****************************************************
    // Decodes
    // ****************************************************
    wire both_high = i_on_above && i_off_above;
    wire both_low = !i_on_above && !i_off_above;
    wire onlow_done = (onlow_r >= P_ON_LOW_CYC - hss_pkg::ONE_CNT);
    wire supply_ok = on_latch_r && !i_overvoltage_in;
    wire state_chg = (state_nxt != state_r);
    wire tmr_hit_settle = (tmr_r >= P_SETTLE_CYC - hss_pkg::ONE_CNT);
    wire tmr_hit_probe = (tmr_r >= P_PROBE_CYC - hss_pkg::ONE_CNT);
    wire tmr_hit_good = (tmr_r >= P_GOOD_CYC - hss_pkg::ONE_CNT);
    wire tmr_in_off = (tmr_r < P_STEP_OFF_CYC);
    wire tmr_hit_ramp = (tmr_r >= P_STEP_RAMP_CYC - hss_pkg::ONE_CNT);
    wire tmr_hit_retry = (tmr_r >= retry_lim_r - hss_pkg::ONE_CNT);
    wire cb_only = i_out_above_breaker && !i_out_above_short;
    wire brk_done = (brk_r >= P_BREAKER_CYC - hss_pkg::ONE_CNT);
    wire overcur = i_out_above_short || (cb_only && brk_done);
    // Wait after a failed probe, sixteen probe periods
    wire [31:0] probe_retry = 32'(P_PROBE_CYC * 32'(hss_pkg::PROBE_RETRY_MULT));
    // ****************************************************
    // Turn-on latch
    // ****************************************************
    // Counts how long both inputs stay low, then holds at the limit until reset
    always_comb begin
        onlow_nxt = both_low ? onlow_r + hss_pkg::ONE_CNT : hss_pkg::ZERO_CNT;
        if (onlow_done) begin
            onlow_nxt = onlow_r;
        end
    end
    // Set on both high, clear on both low long enough, else hold
    always_comb begin
        on_latch_nxt = on_latch_r;
        if (both_high) begin
            on_latch_nxt = 1'b1;
        end else if (both_low && onlow_done) begin
            on_latch_nxt = 1'b0;
        end
    end
    // ****************************************************
    // Sequencer next state
    // ****************************************************
    always_comb begin
        state_nxt = state_r;
        step_cyc_nxt = step_cyc_r;
        retry_lim_nxt = retry_lim_r;
        good_nxt = good_r;
        case (state_r)
            // Switch off, waiting for good supply
            HSS_IDLE: begin
                good_nxt = 1'b0;
                if (supply_ok) begin
                    state_nxt = HSS_SETTLE;
                end
            end
            // Supply must stay good for the whole settle time
            HSS_SETTLE: begin
                if (!supply_ok) begin
                    state_nxt = HSS_IDLE;
                end else if (tmr_hit_settle) begin
                    state_nxt = HSS_PROBE;
                end
            end
            // Probe current on, watch load voltage
            HSS_PROBE: begin
                step_cyc_nxt = 1'b0;
                if (!supply_ok) begin
                    state_nxt = HSS_IDLE;
                end else if (i_load_above_200mv) begin
                    state_nxt = HSS_RAMP;
                end else if (tmr_hit_probe) begin
                    retry_lim_nxt = probe_retry;
                    state_nxt = i_latched_variant ? HSS_FAULT : HSS_RETRY;
                end
            end
            // Controlled ramp, power-up or step cycle
            HSS_RAMP: begin
                if (!supply_ok) begin
                    state_nxt = HSS_IDLE;
                end else if (i_out_below_74) begin
                    state_nxt = HSS_FULL;
                end else if (i_drive_at_90 && !(step_cyc_r && i_input_step_sense)) begin
                    good_nxt = 1'b0;
                    retry_lim_nxt = P_RETRY_CYC;
                    state_nxt = i_latched_variant ? HSS_FAULT : HSS_RETRY;
                end
            end
            // Full enhancement, monitoring overcurrent
            HSS_FULL: begin
                if (!step_cyc_r && i_drive_full && tmr_hit_good) begin
                    good_nxt = 1'b1;
                end
                if (!supply_ok) begin
                    state_nxt = HSS_IDLE;
                end else if (i_input_step_sense) begin
                    if (overcur) begin
                        step_cyc_nxt = 1'b1;
                        state_nxt = HSS_STEP_OFF;
                    end
                end else if (overcur) begin
                    good_nxt = 1'b0;
                    retry_lim_nxt = P_RETRY_CYC;
                    state_nxt = i_latched_variant ? HSS_FAULT : HSS_RETRY;
                end
            end
            // Step cycle: drive off, then wait for ramp start
            HSS_STEP_OFF: begin
                if (!supply_ok) begin
                    state_nxt = HSS_IDLE;
                end else if (tmr_hit_ramp) begin
                    state_nxt = HSS_RAMP;
                end
            end
            // Latched fault, left only by inputs cycled low
            HSS_FAULT: begin
                good_nxt = 1'b0;
                if (!on_latch_r) begin
                    state_nxt = HSS_IDLE;
                end
            end
            // Autoretry wait, then probe again
            HSS_RETRY: begin
                good_nxt = 1'b0;
                if (tmr_hit_retry) begin
                    state_nxt = supply_ok ? HSS_PROBE : HSS_IDLE;
                end
            end
            default: begin
                state_nxt = HSS_IDLE;
            end
        endcase
        if (!supply_ok) begin
            good_nxt = 1'b0;
        end
        if (state_r == HSS_IDLE) begin
            step_cyc_nxt = 1'b0;
        end
    end
    // ****************************************************
    // Timers
    // ****************************************************
    // Shared timer restarts on every state change
    always_comb begin
        tmr_nxt = state_chg ? hss_pkg::ZERO_CNT : tmr_r + hss_pkg::ONE_CNT;
        if (!state_chg && tmr_r == 32'hffff_ffff) begin
            tmr_nxt = tmr_r;
        end
    end
    // Breaker timer runs only while breaker-only level holds at full
    always_comb begin
        brk_nxt = hss_pkg::ZERO_CNT;
        if (state_r == HSS_FULL && !state_chg && cb_only && i_drive_full) begin
            brk_nxt = brk_done ? brk_r : brk_r + hss_pkg::ONE_CNT;
        end
    end
    // ****************************************************
    // Registers
    // ****************************************************
    // State and timers
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_r <= HSS_IDLE;
            tmr_r <= hss_pkg::ZERO_CNT;
            brk_r <= hss_pkg::ZERO_CNT;
            onlow_r <= hss_pkg::ZERO_CNT;
            retry_lim_r <= hss_pkg::ZERO_CNT;
            on_latch_r <= 1'b0;
            step_cyc_r <= 1'b0;
            good_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            tmr_r <= tmr_nxt;
            brk_r <= brk_nxt;
            onlow_r <= onlow_nxt;
            retry_lim_r <= retry_lim_nxt;
            on_latch_r <= on_latch_nxt;
            step_cyc_r <= step_cyc_nxt;
            good_r <= good_nxt;
        end
    end
    // ****************************************************
    // Registered outputs
    // ****************************************************
    wire in_fault = (state_nxt == HSS_FAULT) || (state_nxt == HSS_RETRY);
    wire do_probe = (state_nxt == HSS_PROBE);
    wire do_full = (state_nxt == HSS_FULL);
    wire do_ramp = (state_nxt == HSS_RAMP);
    wire step_off = (state_nxt == HSS_STEP_OFF) && (state_chg || tmr_in_off);
    wire do_off = !(do_full || do_ramp || (state_nxt == HSS_STEP_OFF)) || step_off;
    // Drive outputs follow the next state
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            probe_r <= 1'b0;
            ramp_r <= 1'b0;
            full_r <= 1'b0;
            off_r <= 1'b1;
            fault_r <= 1'b0;
            pg_pin_r <= 1'b0;
        end else begin
            probe_r <= do_probe;
            ramp_r <= do_ramp;
            full_r <= do_full;
            off_r <= do_off;
            fault_r <= in_fault;
            pg_pin_r <= good_nxt ^ i_good_polarity_select;
        end
    end
    assign o_probe_current_pin = probe_r;
    assign o_drive_ramp = ramp_r;
    assign o_drive_full = full_r;
    assign o_drive_off = off_r;
    assign o_fault = fault_r;
    assign o_power_good_out = pg_pin_r;
endmodule
`default_nettype wire
